// File: src/chc_regs.sv
/*
 * card host register block: AXI4-Lite slave, control state, card clock
 * divider with clock-stop, data timeout and status.
 * assumes data path, command engine and dma sit outside and report events.
 */
`timescale 1ns/1ps
module chc_regs (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [chc_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [chc_pkg::AW-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   cardClockPin,
  output logic                   ifaceEnabled,
  output logic                   powerSaveActive,
  output logic                   cardReset,
  output logic                   cmdStart,
  output logic [31:0]            cmdWord,
  output logic [31:0]            cmdArg,
  input  wire logic              cmdDone,
  input  wire logic              rspWordValid,
  input  wire logic [31:0]       rspWord,
  input  wire logic              readActive,
  input  wire logic              writeActive,
  input  wire logic              fifoFull,
  input  wire logic              waitingData,
  input  wire logic              dataBlockDone,
  input  wire logic              underrunEvent,
  input  wire logic              overrunEvent,
  input  wire logic              dmaDone,
  input  wire logic              rxValid,
  input  wire logic [31:0]       rxWord,
  output logic                   txStrobe,
  output logic [31:0]            txWord,
  output logic                   dmaByteMode,
  output logic                   dmaModeOn,
  output logic [7:0]             padByte,
  output logic [15:0]            blockLength,
  output logic [15:0]            blockCount,
  output logic [1:0]             cardSlotSelect,
  output logic                   cardBusWide
);
  import chc_pkg::*;

  chc_state_t  state_reg;
  chc_state_t  state_next;
  logic        wrGo;
  logic        arGo;
  logic        clkStop;
  logic [31:0] wMask;
  logic [31:0] wVal;
  logic [31:0] statusWord;
  logic [8:0]  baseHalf;
  logic [8:0]  psFactor;
  logic [17:0] halfTarget;
  logic [23:0] toLimit;
  logic [31:0] bcntNew;

  // ***********************************************************
  // bus handshakes and byte lanes
  // ***********************************************************
  assign s_axi_awready = !state_reg.axi.awHeld && !state_reg.axi.bValid;
  assign s_axi_wready  = !state_reg.axi.wHeld && !state_reg.axi.bValid;
  assign s_axi_arready = !state_reg.axi.rValid;
  assign wrGo = state_reg.axi.awHeld && state_reg.axi.wHeld &&
                !state_reg.axi.bValid;
  assign arGo = s_axi_arvalid && s_axi_arready;

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wMask[8*i +: 8] = {8{state_reg.axi.wStrb[i]}};
  end
  assign wVal = state_reg.axi.wData & wMask;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // block count merged as a full word, low half kept
  assign bcntNew = merge({16'h0000, state_reg.bcnt}, state_reg.axi.wData,
                         wMask);

  // ***********************************************************
  // derived values
  // ***********************************************************
  always_comb begin
    statusWord = SR_RESET;
    statusWord[SR_COMMAND_READY_FLAG] = state_reg.cmdReady;
    statusWord[SR_DATA_TIMEOUT_ERROR] = state_reg.dtoErr;
    statusWord[SR_OVERRUN_FLAG] = state_reg.ovr;
    statusWord[SR_UNDERRUN_FLAG] = state_reg.unr;
  end

  assign baseHalf = {1'b0, state_reg.mode[MR_CARD_CLOCK_DIVIDER +: 8]} + 9'h001;
  assign psFactor = (9'h001 << state_reg.mode[MR_PSDIV +: 3]) + 9'h001;
  assign halfTarget = state_reg.psOn ? 18'(baseHalf) * 18'(psFactor)
                                     : 18'(baseHalf);
  assign clkStop = fifoFull &&
    ((state_reg.mode[MR_RDSTOP] && readActive) ||
     (state_reg.mode[MR_WRSTOP] && writeActive));
  assign toLimit = 24'(state_reg.dto[DT_CYC +: 4]) <<
                   MUL_SHIFT[state_reg.dto[DT_MUL +: 3]];

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    chc_axi_t keep;
    keep = state_reg.axi;
    state_next = state_reg;
    state_next.cmdStart = 1'b0;
    state_next.txPulse = 1'b0;
    state_next.rstPulse = 1'b0;
    if (state_reg.axi.bValid && s_axi_bready) begin
      state_next.axi.bValid = 1'b0;
    end
    if (state_reg.axi.rValid && s_axi_rready) begin
      state_next.axi.rValid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.axi.awHeld = 1'b1;
      state_next.axi.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.axi.wHeld = 1'b1;
      state_next.axi.wData = s_axi_wdata;
      state_next.axi.wStrb = s_axi_wstrb;
    end
    if (wrGo) begin
      state_next.axi.awHeld = 1'b0;
      state_next.axi.wHeld = 1'b0;
      state_next.axi.bValid = 1'b1;
      state_next.axi.bResp = RESP_OKAY;
      case (state_reg.axi.awAddr)
        OFS_CTRL: begin
          if (wVal[CR_DIS]) begin
            state_next.ifaceOn = 1'b0;
          end else if (wVal[CR_EN]) begin
            state_next.ifaceOn = 1'b1;
          end
          if (wVal[CR_PSDIS]) begin
            state_next.psOn = 1'b0;
          end else if (wVal[CR_PSEN]) begin
            state_next.psOn = 1'b1;
          end
        end
        OFS_MODE: begin
          state_next.mode = merge(state_reg.mode, state_reg.axi.wData,
                                  wMask);
        end
        OFS_DTO: begin
          state_next.dto = merge(state_reg.dto, state_reg.axi.wData,
                                 wMask & DTO_MASK);
        end
        OFS_SLOT: begin
          state_next.slot = merge(state_reg.slot, state_reg.axi.wData,
                                  wMask & SC_MASK);
        end
        OFS_ARG: begin
          state_next.arg = merge(state_reg.arg, state_reg.axi.wData, wMask);
        end
        OFS_CMD: begin
          if (state_reg.cmdReady) begin
            state_next.cmd = wVal;
            state_next.cmdStart = 1'b1;
            state_next.cmdReady = 1'b0;
            state_next.dtoErr = 1'b0;
            state_next.rspRd = '0;
            state_next.rspWr = '0;
          end
        end
        OFS_BLK: begin
          state_next.mode = merge(state_reg.mode, state_reg.axi.wData,
                                  {wMask[MR_BLOCK_LENGTH +: LEN_W], 16'h0000});
          state_next.bcnt = bcntNew[LEN_W-1:0];
        end
        OFS_TXD: begin
          state_next.txData = wVal;
          state_next.txPulse = 1'b1;
        end
        OFS_IEN: state_next.imask = state_reg.imask | wVal;
        OFS_IDIS: state_next.imask = state_reg.imask & ~wVal;
        OFS_RSP0, OFS_RSP1, OFS_RSP2, OFS_RSP3, OFS_RXD, OFS_STAT,
        OFS_IMASK: state_next.axi.bResp = RESP_OKAY;
        default: state_next.axi.bResp = RESP_SLVERR;
      endcase
    end
    if (arGo) begin
      state_next.axi.rValid = 1'b1;
      state_next.axi.rResp = RESP_OKAY;
      state_next.axi.rData = '0;
      case (s_axi_araddr)
        OFS_MODE: state_next.axi.rData = state_reg.mode;
        OFS_DTO: state_next.axi.rData = state_reg.dto;
        OFS_SLOT: state_next.axi.rData = state_reg.slot;
        OFS_ARG: state_next.axi.rData = state_reg.arg;
        OFS_BLK: begin
          state_next.axi.rData = {state_reg.mode[MR_BLOCK_LENGTH +: LEN_W],
                                  state_reg.bcnt};
        end
        OFS_RSP0, OFS_RSP1, OFS_RSP2, OFS_RSP3: begin
          state_next.axi.rData = state_reg.rsp[state_reg.rspRd];
          state_next.rspRd = state_reg.rspRd + 2'h1;
        end
        OFS_RXD: state_next.axi.rData = state_reg.rxData;
        OFS_STAT: state_next.axi.rData = statusWord;
        OFS_IMASK: state_next.axi.rData = state_reg.imask;
        OFS_CTRL, OFS_CMD, OFS_TXD, OFS_IEN,
        OFS_IDIS: state_next.axi.rResp = RESP_OKAY;
        default: state_next.axi.rResp = RESP_SLVERR;
      endcase
    end
    // events from the link side; a set wins over any clear above
    if (cmdDone) begin
      state_next.cmdReady = 1'b1;
    end
    if (rspWordValid) begin
      state_next.rsp[state_reg.rspWr] = rspWord;
      state_next.rspWr = state_reg.rspWr + 2'h1;
    end
    if (rxValid) begin
      state_next.rxData = rxWord;
    end
    if (state_reg.mode[MR_DMA] && dmaDone) begin
      state_next.ovr = 1'b0;
      state_next.unr = 1'b0;
    end
    if (overrunEvent) begin
      state_next.ovr = 1'b1;
    end
    if (underrunEvent) begin
      state_next.unr = 1'b1;
    end
    // data timeout between blocks
    if (!waitingData || dataBlockDone || !state_reg.ifaceOn) begin
      state_next.waitCnt = '0;
    end else if (state_reg.waitCnt != '1) begin
      state_next.waitCnt = state_reg.waitCnt + 24'h000001;
    end
    if (waitingData && state_reg.ifaceOn &&
        state_reg.waitCnt > toLimit) begin
      state_next.dtoErr = 1'b1;
    end
    // card clock divider, held while halted
    if (!state_reg.ifaceOn) begin
      state_next.divCnt = '0;
      state_next.cardClk = 1'b0;
    end else if (!clkStop) begin
      if (state_reg.divCnt >= halfTarget - 18'h00001) begin
        state_next.divCnt = '0;
        state_next.cardClk = !state_reg.cardClk;
      end else begin
        state_next.divCnt = state_reg.divCnt + 18'h00001;
      end
    end
    // soft reset keeps the pending bus answer alive
    if (wrGo && state_reg.axi.awAddr == OFS_CTRL && wVal[CR_SOFT_RESET_CMD]) begin
      keep = state_next.axi;
      state_next = ST_RESET;
      state_next.axi = keep;
      state_next.rstPulse = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign s_axi_bvalid    = state_reg.axi.bValid;
  assign s_axi_bresp     = state_reg.axi.bResp;
  assign s_axi_rvalid    = state_reg.axi.rValid;
  assign s_axi_rdata     = state_reg.axi.rData;
  assign s_axi_rresp     = state_reg.axi.rResp;
  assign cardClockPin    = state_reg.cardClk;
  assign ifaceEnabled    = state_reg.ifaceOn;
  assign powerSaveActive = state_reg.psOn;
  assign cardReset       = state_reg.rstPulse;
  assign cmdStart        = state_reg.cmdStart;
  assign cmdWord         = state_reg.cmd;
  assign cmdArg          = state_reg.arg;
  assign txStrobe        = state_reg.txPulse;
  assign txWord          = state_reg.txData;
  assign dmaByteMode     = state_reg.mode[MR_BYTE];
  assign dmaModeOn       = state_reg.mode[MR_DMA];
  assign padByte = state_reg.mode[MR_PAD] ? PAD_ONES : PAD_ZERO;
  assign blockLength =
    (state_reg.cmd[CM_TRTYP +: 3] == TRTYP_SDIO_BYTE) ? '0
      : state_reg.mode[MR_BLOCK_LENGTH +: LEN_W];
  assign blockCount      = state_reg.bcnt;
  assign cardSlotSelect  = state_reg.slot[SC_SEL +: 2];
  assign cardBusWide     = state_reg.slot[SC_BUS];

  // ***********************************************************
  // checks
  // ***********************************************************
  logic        tglNow;
  logic        dirty_reg;
  logic [17:0] gap_reg;
  assign tglNow = state_next.cardClk != state_reg.cardClk;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dirty_reg <= 1'b1;
      gap_reg <= '0;
    end else begin
      gap_reg <= tglNow ? 18'h00001 : gap_reg + 18'h00001;
      dirty_reg <= tglNow ? (clkStop || wrGo)
                   : (dirty_reg || clkStop || wrGo || !state_reg.ifaceOn);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence ctrlWr;
    wrGo && state_reg.axi.awAddr == OFS_CTRL;
  endsequence
  sequence cmdWrBusy;
    wrGo && state_reg.axi.awAddr == OFS_CMD && !state_reg.cmdReady;
  endsequence

  iface_enable_a: assert property (ctrlWr and (wVal[CR_EN] &&
      !wVal[CR_DIS] && !wVal[CR_SOFT_RESET_CMD]) |=> ifaceEnabled)
    else $error("enable write did not enable");
  iface_disable_a: assert property (ctrlWr and wVal[CR_DIS]
      |=> !ifaceEnabled)
    else $error("disable write did not disable");
  psave_enter_a: assert property (ctrlWr and (wVal[CR_PSEN] &&
      !wVal[CR_PSDIS] && !wVal[CR_SOFT_RESET_CMD]) |=> powerSaveActive)
    else $error("power save not entered");
  psave_leave_a: assert property (ctrlWr and wVal[CR_PSDIS]
      |=> !powerSaveActive)
    else $error("power save not left");
  soft_reset_a: assert property (ctrlWr and wVal[CR_SOFT_RESET_CMD] |=>
      (state_reg.mode == '0 && cardReset && !ifaceEnabled) ##1 !cardReset)
    else $error("soft reset incomplete");
  clk_period_a: assert property (tglNow && !dirty_reg && !clkStop
      |-> gap_reg == halfTarget)
    else $error("card clock half period wrong");
  clk_halt_a: assert property (clkStop |=> $stable(cardClockPin))
    else $error("card clock ran while halted");
  dto_flag_a: assert property (waitingData && ifaceEnabled &&
      state_reg.waitCnt > toLimit |=> statusWord[SR_DATA_TIMEOUT_ERROR])
    else $error("timeout flag missing");
  cmd_protect_a: assert property (cmdWrBusy |=>
      $stable(cmdWord) && !cmdStart)
    else $error("busy command register changed");
  dma_clear_a: assert property (dmaModeOn && dmaDone && !overrunEvent
      && !underrunEvent |=> !state_reg.ovr && !state_reg.unr)
    else $error("dma done left error flags");
  reset_value_a: assert property (disable iff (1'b0) sys_rst
      |=> statusWord == SR_RESET && state_reg.mode == '0)
    else $error("reset values wrong");

endmodule // chc_regs

// File: src/chc_pkg.sv
/*
 * constants, field layout and state type of the card host register block.
 * assumes an AXI4-Lite master with 32-bit data and byte addresses.
 */
package chc_pkg;

  localparam int        AW         = 8;
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_MODE  = 8'h04;
  localparam logic [7:0] OFS_DTO   = 8'h08;
  localparam logic [7:0] OFS_SLOT  = 8'h0c;
  localparam logic [7:0] OFS_ARG   = 8'h10;
  localparam logic [7:0] OFS_CMD   = 8'h14;
  localparam logic [7:0] OFS_BLK   = 8'h18;
  localparam logic [7:0] OFS_RSP0  = 8'h20;
  localparam logic [7:0] OFS_RSP1  = 8'h24;
  localparam logic [7:0] OFS_RSP2  = 8'h28;
  localparam logic [7:0] OFS_RSP3  = 8'h2c;
  localparam logic [7:0] OFS_RXD   = 8'h30;
  localparam logic [7:0] OFS_TXD   = 8'h34;
  localparam logic [7:0] OFS_STAT  = 8'h40;
  localparam logic [7:0] OFS_IEN   = 8'h44;
  localparam logic [7:0] OFS_IDIS  = 8'h48;
  localparam logic [7:0] OFS_IMASK = 8'h4c;

  localparam int CR_EN = 0, CR_DIS = 1, CR_PSEN = 2, CR_PSDIS = 3;
  localparam int CR_SOFT_RESET_CMD = 7;
  localparam int MR_CARD_CLOCK_DIVIDER = 0, MR_PSDIV = 8, MR_RDSTOP = 11;
  localparam int MR_WRSTOP = 12, MR_BYTE = 13, MR_PAD = 14, MR_DMA = 15;
  localparam int MR_BLOCK_LENGTH = 16, BR_BCNT = 0, LEN_W = 16;
  localparam int DT_CYC = 0, DT_MUL = 4, SC_SEL = 0, SC_BUS = 7;
  localparam int CM_TRTYP = 19;
  localparam int SR_COMMAND_READY_FLAG = 0, SR_DATA_TIMEOUT_ERROR = 22, SR_OVERRUN_FLAG = 30, SR_UNDERRUN_FLAG = 31;

  localparam logic [2:0]  TRTYP_SDIO_BYTE = 3'h4;
  localparam logic [31:0] SR_RESET = 32'h0000c0e5;
  localparam logic [31:0] DTO_MASK = 32'h0000007f;
  localparam logic [31:0] SC_MASK  = 32'h00000083;
  localparam logic [7:0]  PAD_ZERO = 8'h00;
  localparam logic [7:0]  PAD_ONES = 8'hff;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // multiplier codes as shift counts: 1,16,128,256,1024,4096,65536,1048576
  localparam logic [4:0] MUL_SHIFT [8] = '{5'h00, 5'h04, 5'h07, 5'h08,
                                           5'h0a, 5'h0c, 5'h10, 5'h14};

  typedef struct packed {
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } chc_axi_t;

  typedef struct packed {
    chc_axi_t         axi;
    logic             ifaceOn;
    logic             psOn;
    logic [31:0]      mode;
    logic [31:0]      dto;
    logic [31:0]      slot;
    logic [31:0]      arg;
    logic [31:0]      cmd;
    logic             cmdStart;
    logic             cmdReady;
    logic [15:0]      bcnt;
    logic [3:0][31:0] rsp;
    logic [1:0]       rspRd;
    logic [1:0]       rspWr;
    logic [31:0]      rxData;
    logic [31:0]      txData;
    logic             txPulse;
    logic [31:0]      imask;
    logic             dtoErr;
    logic             ovr;
    logic             unr;
    logic [23:0]      waitCnt;
    logic [17:0]      divCnt;
    logic             cardClk;
    logic             rstPulse;
  } chc_state_t;

  localparam chc_state_t ST_RESET = '{cmdReady: 1'b1, default: '0};

endpackage

// File: bench/chc_card_model.sv
/* card side model: answers a command with four response words,
   one receive word and command-done, promptly or slowly.
   assumes the register block's link-side ports on clk_sys. */
`timescale 1ns/1ps
module chc_card_model (
  input  wire logic        clk_sys,
  input  wire logic        cmdStart,
  input  wire logic        slowAns,
  output logic             cmdDone = 1'b0,
  output logic             rspWordValid = 1'b0,
  output logic [31:0]      rspWord = 32'h0,
  output logic             rxValid = 1'b0,
  output logic [31:0]      rxWord = 32'h0
);
  initial forever begin
    @(posedge clk_sys);
    if (cmdStart === 1'b1) begin
      repeat (slowAns ? 30 : 2) @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
        rspWordValid <= 1'b1;
        rspWord <= 32'hc0de0000 + i;
        @(posedge clk_sys);
      end
      // released lines show a changed value, not the last one
      rspWordValid <= 1'b0;
      rspWord <= ~rspWord;
      rxValid <= 1'b1;
      rxWord <= 32'h5a5a0f0f;
      cmdDone <= 1'b1;
      @(posedge clk_sys);
      rxValid <= 1'b0;
      rxWord <= 32'ha5a5f0f0;
      cmdDone <= 1'b0;
    end
  end
endmodule // chc_card_model

// File: bench/tb_chc_regs.sv
/* testbench of the card host register block over AXI4-Lite.
   assumes chc_pkg and the card side model are compiled first. */
`timescale 1ns/1ps
module tb_chc_regs;
  import chc_pkg::*;
  logic clk_sys = 0, sys_rst = 1, slowAns = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic readActive = 0, writeActive = 0, fifoFull = 0, waitingData = 0;
  logic dataBlockDone = 0, underrunEvent = 0, overrunEvent = 0, dmaDone = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cardClockPin, ifaceEnabled, powerSaveActive;
  logic cardReset, cmdStart, cmdDone, rspWordValid, rxValid, txStrobe;
  logic dmaByteMode, dmaModeOn, cardBusWide;
  logic [1:0] s_axi_bresp, s_axi_rresp, cardSlotSelect;
  logic [31:0] s_axi_rdata, cmdWord, cmdArg, rspWord, rxWord, txWord, d;
  logic [7:0] padByte;
  logic [15:0] blockLength, blockCount;
  int mismatches = 0, n_tests = 0, nStarts = 0, p;
  int nTx = 0, nRst = 0;
  logic [1:0] lastB;
  chc_regs chc_regs_i (.clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .cardClockPin, .ifaceEnabled,
    .powerSaveActive, .cardReset, .cmdStart, .cmdWord, .cmdArg, .cmdDone,
    .rspWordValid, .rspWord, .readActive, .writeActive, .fifoFull,
    .waitingData, .dataBlockDone, .underrunEvent, .overrunEvent, .dmaDone,
    .rxValid, .rxWord, .txStrobe, .txWord, .dmaByteMode, .dmaModeOn,
    .padByte, .blockLength, .blockCount, .cardSlotSelect, .cardBusWide);
  chc_card_model chc_card_model_i (.clk_sys, .cmdStart, .slowAns, .cmdDone,
    .rspWordValid, .rspWord, .rxValid, .rxWord);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (cmdStart === 1'b1) nStarts <= nStarts + 1;
  always @(posedge clk_sys) if (txStrobe === 1'b1) nTx <= nTx + 1;
  always @(posedge clk_sys) if (cardReset === 1'b1) nRst <= nRst + 1;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang;
    chk("handshake", 32'h0, 32'h1);
    give_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit aw, w;
    int n;
    @(posedge clk_sys);
    aw = 1;
    w = 1;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_bvalid === 1'b1) break;
      if (aw && s_axi_awready === 1'b1) begin aw = 0; s_axi_awvalid <= 0; end
      if (w && s_axi_wready === 1'b1) begin w = 0; s_axi_wvalid <= 0; end
      if (++n > 40) hang();
    end
    lastB = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_rvalid === 1'b1) break;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      if (++n > 40) hang();
    end
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic cper(output int q);
    int n, r1;
    logic o;
    n = 0;
    r1 = -1;
    o = cardClockPin;
    forever begin
      @(posedge clk_sys);
      n++;
      if (cardClockPin === 1'b1 && o === 1'b0) begin
        if (r1 >= 0) break;
        r1 = n;
      end
      o = cardClockPin;
      if (n > 200) hang();
    end
    q = n - r1;
  endtask
  task automatic t_reset;
    logic [7:0] ofs [9];
    logic [1:0] r;
    ofs = '{OFS_STAT, OFS_MODE, OFS_DTO, OFS_SLOT, OFS_ARG, OFS_BLK,
            OFS_RSP0, OFS_RXD, OFS_IMASK};
    for (int i = 0; i < 9; i++) begin
      rd(ofs[i], d, r);
      chk("reset value", d, ofs[i] == OFS_STAT ? SR_RESET : 32'h0);
    end
    rd(8'h1c, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h1c, 32'h0);
    chk("unmapped wr", {30'h0, lastB}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_ctrl;
    logic [3:0] cw [8];
    logic [1:0] ex [8];
    cw = '{4'h3, 4'h1, 4'h0, 4'h2, 4'hc, 4'h4, 4'h0, 4'h8};
    ex = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0};
    wr(OFS_MODE, 32'h100);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL, {28'h0, cw[i]});
      chk("enables",
          {ifaceEnabled, powerSaveActive}, ex[i]);
    end
  endtask
  task automatic t_mode;
    logic [1:0] r;
    wr(OFS_MODE, 32'h00036000);
    chk("byte pad",
        {dmaModeOn, dmaByteMode, padByte}, 32'h1ff);
    rd(OFS_BLK, d, r);
    chk("shared len", {blockLength, d[31:16]}, 32'h30003);
    wr(OFS_BLK, 32'h00070009);
    chk("block count", {blockLength, blockCount}, 32'h70009);
    rd(OFS_MODE, d, r);
    chk("mode len", d, 32'h00076000);
    wr(OFS_MODE, 32'h00048000);
    chk("word pad",
        {dmaModeOn, dmaByteMode, padByte}, 32'h200);
    wr(OFS_SLOT, 32'h81);
    chk("slot", {cardBusWide, cardSlotSelect}, 32'h5);
    wr(OFS_SLOT, 32'h0);
    chk("slot", {cardBusWide, cardSlotSelect}, 32'h0);
  endtask
  task automatic t_clock;
    bit st;
    logic q;
    wr(OFS_MODE, 32'h1);
    wr(OFS_CTRL, 32'h1);
    cper(p);
    chk("card period", p, 4);
    wr(OFS_MODE, 32'h101);
    wr(OFS_CTRL, 32'h4);
    cper(p);
    chk("saving period", p, 12);
    wr(OFS_CTRL, 32'h8);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_MODE, k ? 32'h1001 : 32'h0801);
      readActive <= !k;
      writeActive <= k;
      fifoFull <= 1;
      repeat (4) @(posedge clk_sys);
      q = cardClockPin;
      st = 1;
      repeat (20) @(posedge clk_sys) if (cardClockPin !== q) st = 0;
      chk("clock halted", st, 1);
      fifoFull <= 0;
      cper(p);
      chk("clock resumed", p, 4);
    end
    readActive <= 0;
    writeActive <= 0;
  endtask
  task automatic t_dto;
    logic [1:0] r;
    wr(OFS_DTO, 32'h13);
    waitingData <= 1;
    repeat (38) @(posedge clk_sys);
    rd(OFS_STAT, d, r);
    chk("before limit", d[SR_DATA_TIMEOUT_ERROR], 0);
    repeat (30) @(posedge clk_sys);
    rd(OFS_STAT, d, r);
    chk("past limit", d[SR_DATA_TIMEOUT_ERROR], 1);
    waitingData <= 0;
  endtask
  task automatic t_cmd;
    int n0, n;
    logic [1:0] r;
    slowAns <= 1;
    n0 = nStarts;
    wr(OFS_ARG, 32'h12345678);
    chk("write resp", {30'h0, lastB}, {30'h0, RESP_OKAY});
    wr(OFS_CMD, 32'h00200000);
    chk("start", nStarts, n0 + 1);
    chk("sdio byte len", {blockLength, cmdArg[15:0]}, 32'h5678);
    wr(OFS_CMD, 32'h1);
    chk("busy command", nStarts, n0 + 1);
    chk("busy word", cmdWord, 32'h00200000);
    n = 0;
    do begin
      rd(OFS_STAT, d, r);
      if (++n > 40) hang();
    end while (d[SR_COMMAND_READY_FLAG] !== 1'b1);
    for (int i = 0; i < 8; i++) begin
      rd(i < 4 ? OFS_RSP0 + 8'(4 * i) : OFS_RSP0, d, r);
      chk("response", d, 32'hc0de0000 + (i % 4));
    end
    rd(OFS_RXD, d, r);
    chk("receive", d, 32'h5a5a0f0f);
    wr(OFS_TXD, 32'hbeef);
    chk("transmit", txWord, 32'hbeef);
    chk("transmit pulse", nTx, 1);
    slowAns <= 0;
  endtask
  task automatic t_dma_soft_reset_cmd;
    logic [1:0] r;
    wr(OFS_MODE, 32'h8000);
    overrunEvent <= 1;
    underrunEvent <= 1;
    @(posedge clk_sys);
    overrunEvent <= 0;
    underrunEvent <= 0;
    rd(OFS_STAT, d, r);
    chk("run flags", d[31:30], 3);
    dmaDone <= 1;
    @(posedge clk_sys);
    dmaDone <= 0;
    rd(OFS_STAT, d, r);
    chk("run flags", d[31:30], 0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h80);
    chk("soft reset", ifaceEnabled, 0);
    chk("link abort", nRst, 1);
    rd(OFS_MODE, d, r);
    chk("soft mode", d, 0);
    rd(OFS_STAT, d, r);
    chk("soft status", d, SR_RESET);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 0;
    t_reset();
    t_ctrl();
    t_mode();
    t_clock();
    t_dto();
    t_cmd();
    t_dma_soft_reset_cmd();
    give_verdict();
  end
endmodule // tb_chc_regs
